// file: hw/hws_params.svh
// Purpose: Constants for the haptic waveform sequencer
// Assumes: 200 MHz clock
// Notes: Times in their own units, cycle counts derived
`ifndef HWS_PARAMS_SVH
`define HWS_PARAMS_SVH
`define HWS_CLK_MHZ 200
`define HWS_TICK_LONG_US 5000
`define HWS_TICK_SHORT_US 1000
`define HWS_WAIT_UNIT_US 10000
`define HWS_CYC(us) ((us) * `HWS_CLK_MHZ)
`define HWS_SLOTS 8
`define HWS_OFS_RESET 8'h00
`define HWS_RES_NUM_X100 47843
`define HWS_RES_BASE 719
`define HWS_WAIT_BIT 7
`define HWS_LIB_LEN 4
`endif

// file: hw/hws_pkg.sv
// Purpose: Types for the haptic waveform sequencer
// Assumes: Included with hws_params.svh
// Notes: Modes and process states
package hws_pkg;
  typedef enum logic [1:0] {
    HWS_MODE_RTP,
    HWS_MODE_SEQ,
    HWS_MODE_DIAG,
    HWS_MODE_CAL
  } hws_mode_e;
  typedef enum logic [2:0] {
    HWS_ST_IDLE,
    HWS_ST_FETCH,
    HWS_ST_PLAY,
    HWS_ST_WAIT,
    HWS_ST_RTP,
    HWS_ST_CAL,
    HWS_ST_DIAG
  } hws_state_e;
  typedef enum logic [1:0] {
    HWS_SEG_OD,
    HWS_SEG_SP,
    HWS_SEG_SN,
    HWS_SEG_BRK
  } hws_seg_e;
endpackage : hws_pkg

// file: hw/hws_tick_gen.sv
// Purpose: Library tick enable divider
// Assumes: Restart pulse aligns ticks
// Notes: Period picks 5 ms or 1 ms
`timescale 1ns/1ps
`include "hws_params.svh"
module hws_tick_gen import hws_pkg::*; #(
  parameter int LONG_CYC = `HWS_CYC(`HWS_TICK_LONG_US),
  parameter int SHORT_CYC = `HWS_CYC(`HWS_TICK_SHORT_US),
  parameter int WAIT_CYC = `HWS_CYC(`HWS_WAIT_UNIT_US)
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_restart,
  input wire logic i_short,
  output logic o_tick,
  output logic o_wait_tick
);
  logic [31:0] cnt_reg;
  logic [31:0] wcnt_reg;
  wire [31:0] limit = i_short ? SHORT_CYC[31:0] : LONG_CYC[31:0];
  assign o_tick = (cnt_reg == limit - 32'h1);
  assign o_wait_tick = (wcnt_reg == WAIT_CYC[31:0] - 32'h1);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_restart || o_tick) cnt_reg <= 32'h0;
    else cnt_reg <= cnt_reg + 32'h1;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_restart || o_wait_tick) wcnt_reg <= 32'h0;
    else wcnt_reg <= wcnt_reg + 32'h1;
  end
endmodule : hws_tick_gen

// file: hw/hws_sequencer.sv
// Purpose: Playback front end of a haptic driver
// Assumes: Register fields arrive as plain ports
// Notes: Analog loop modelled by its inputs only
`timescale 1ns/1ps
`include "hws_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Calibration length from setting, or from trigger pin length when selected
// - Loop-gain setting passed to the loop; higher settles faster, less stable
// - At calibration end, write best back-EMF gain into gain field
// - Effective back-EMF gain rises with sample time setting
// - Diagnostic open or short sets the fault flag
// - Resistance result is 8 bits; R = 478.43*code/(719+4*K)
// - Resonant start follows existing motion, else default direction
// - Open loop ignores closed-loop settings for library and real-time
// - Open loop peak from clamp, scaled by amplitude code
// - Open-loop resonant drive period from period field
// - Sine or square in open-loop resonant only
// - Auto-brake in open loop uses closed loop while braking
// - Mode selects sequencer, real-time playback, diagnostics or calibration
// - Two read-only libraries selected by library select bit
// - Four signed offsets, default zero, added to segment times
// - Offsets apply to library waveforms, never real-time playback
// - Most positive is overdrive, most negative brake; ramps stretched
// - Tick is 5 ms, or 1 ms with interval bit set
// - Play slots from first until zero identifier or eight slots
// - Top bit clear is identifier; set is wait of low bits times 10 ms
// - Repeat each waveform per loop setting before next slot
// - Replay sequence main-loop count extra times then standby
// - Processes begin only on go bit or trigger pin
// - Process ends on completion or stop trigger
module hws_sequencer import hws_pkg::*; #(
  parameter int CAL_UNIT_CYC = `HWS_CYC(`HWS_TICK_LONG_US),
  parameter int LONG_CYC = `HWS_CYC(`HWS_TICK_LONG_US),
  parameter int SHORT_CYC = `HWS_CYC(`HWS_TICK_SHORT_US),
  parameter int WAIT_CYC = `HWS_CYC(`HWS_WAIT_UNIT_US)
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_go_set,
  input wire logic i_go_clr,
  input wire logic i_trigger_irq_pin,
  input wire logic i_trigger_pin_function,
  input wire logic [1:0] i_mode,
  input wire logic i_library_select,
  input wire logic i_playback_interval,
  input wire logic i_slot_we,
  input wire logic [2:0] i_slot_idx,
  input wire logic [7:0] i_slot_wdata,
  input wire logic [1:0] i_per_waveform_repeat,
  input wire logic [1:0] i_sequence_repeat_count,
  input wire logic [7:0] i_overdrive_time_ofs,
  input wire logic [7:0] i_sustain_pos_time_ofs,
  input wire logic [7:0] i_sustain_neg_time_ofs,
  input wire logic [7:0] i_brake_time_ofs,
  input wire logic [7:0] i_realtime_amplitude_playback,
  input wire logic i_openloop,
  input wire logic i_lra_sel,
  input wire logic [7:0] i_peak_clamp_level,
  input wire logic [6:0] i_openloop_period,
  input wire logic i_drive_shape_sel,
  input wire logic i_openloop_autobrake_en,
  input wire logic [1:0] i_cal_time,
  input wire logic [1:0] i_loop_gain,
  input wire logic [1:0] i_sample_time,
  input wire logic [1:0] i_backemf_amp_gain_wr,
  input wire logic i_backemf_amp_gain_we,
  input wire logic [1:0] i_cal_best_gain,
  input wire logic i_motion_present,
  input wire logic i_motion_dir,
  input wire logic i_diag_open,
  input wire logic i_diag_short,
  input wire logic [7:0] i_diag_meas,
  output logic o_go,
  output logic [7:0] o_slot_rdata,
  output logic o_busy,
  output logic [7:0] o_drive_level,
  output logic o_drive_neg,
  output logic o_closed_loop,
  output logic o_square_shape,
  output logic [6:0] o_drive_period,
  output logic [1:0] o_loop_gain,
  output logic [1:0] o_backemf_amp_gain,
  output logic [3:0] o_eff_backemf_amp_gain,
  output logic o_diag_fault_flag,
  output logic [7:0] o_resistance_meas
);
  hws_state_e st_reg;
  logic [7:0] slot_reg [`HWS_SLOTS];
  logic go_reg;
  logic [2:0] slot_ptr_reg;
  logic [1:0] rep_reg;
  logic [1:0] main_reg;
  logic [1:0] seg_reg;
  logic [8:0] seg_left_reg;
  logic [6:0] wait_left_reg;
  logic [6:0] wid_reg;
  logic neg_dir_reg;
  logic [31:0] cal_cnt_reg;
  logic [1:0] bgain_reg;
  logic fault_reg;
  logic [7:0] res_reg;
  logic [7:0] level_reg;
  logic pin_d_reg;
  logic tick;
  logic wait_tick;

  // Signed offset added to unsigned tick count, floored at one tick
  function automatic logic [8:0] hws_adj(input logic [7:0] base, input logic [7:0] ofs);
    logic signed [10:0] sum;
    sum = $signed({3'b000, base}) + $signed({{3{ofs[7]}}, ofs});
    hws_adj = (sum < 11'sd1) ? 9'h001 : sum[8:0];
  endfunction : hws_adj

  // Library: per effect segment amplitude and tick length
  function automatic logic [7:0] hws_lib_amp(input logic lib, input logic [1:0] seg);
    case (seg)
      2'd0: hws_lib_amp = 8'h7F;
      2'd1: hws_lib_amp = lib ? 8'h50 : 8'h40;
      2'd2: hws_lib_amp = lib ? 8'hC0 : 8'hB0;
      default: hws_lib_amp = 8'h80;
    endcase
  endfunction : hws_lib_amp

  function automatic logic [7:0] hws_lib_time(input logic lib, input logic [6:0] id,
                                               input logic [1:0] seg);
    hws_lib_time = {4'h0, id[3:0]} + (lib ? 8'h02 : 8'h04) + {6'h00, seg};
  endfunction : hws_lib_time

  hws_tick_gen #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC),
    .WAIT_CYC(WAIT_CYC)
  ) u_tick (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_restart(st_reg == HWS_ST_FETCH),
    .i_short(i_playback_interval),
    .o_tick(tick),
    .o_wait_tick(wait_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger decode
  wire pin_rise = i_trigger_pin_function && i_trigger_irq_pin && !pin_d_reg;
  wire pin_fall = i_trigger_pin_function && !i_trigger_irq_pin && pin_d_reg;
  wire start = (st_reg == HWS_ST_IDLE) && (i_go_set || pin_rise);
  wire stop_req = (st_reg != HWS_ST_IDLE) && i_go_clr;
  wire cal_pin_len = (i_cal_time == 2'b11);
  wire [31:0] cal_len = {30'h0, i_cal_time} * CAL_UNIT_CYC[31:0] + CAL_UNIT_CYC[31:0];
  wire cal_done = cal_pin_len ? pin_fall : (cal_cnt_reg >= cal_len - 32'h1);
  wire [7:0] cur_slot = slot_reg[slot_ptr_reg];
  wire slot_wait = cur_slot[`HWS_WAIT_BIT];
  wire seq_end = (slot_ptr_reg == 3'(`HWS_SLOTS - 1));
  wire [7:0] seg_ofs = (seg_reg == 2'd0) ? i_overdrive_time_ofs :
                       (seg_reg == 2'd1) ? i_sustain_pos_time_ofs :
                       (seg_reg == 2'd2) ? i_sustain_neg_time_ofs : i_brake_time_ofs;
  wire [8:0] seg_len = hws_adj(hws_lib_time(i_library_select, wid_reg, seg_reg),
                               seg_ofs);
  wire next_slot_zero = seq_end || (slot_reg[slot_ptr_reg + 3'h1] == 8'h00);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) pin_d_reg <= 1'b0;
    else pin_d_reg <= i_trigger_irq_pin;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < `HWS_SLOTS; k++) slot_reg[k] <= 8'h00;
    end else if (i_slot_we) begin
      slot_reg[i_slot_idx] <= i_slot_wdata;
    end
  end
  assign o_slot_rdata = slot_reg[i_slot_idx];

  ////////////////////////////////////////////////////////////////////////////////
  // Process state machine
  wire seg_last_tick = (st_reg == HWS_ST_PLAY) && tick && (seg_left_reg == 9'h001);
  wire wave_done = seg_last_tick && (seg_reg == 2'd3);
  wire slot_done = (wave_done && (rep_reg == 2'd0)) ||
                   ((st_reg == HWS_ST_WAIT) && wait_tick && (wait_left_reg <= 7'h01));
  wire seq_done = slot_done && next_slot_zero && (main_reg == 2'd0);
  wire first_zero = (st_reg == HWS_ST_FETCH) && (cur_slot == 8'h00);
  wire end_proc = stop_req || seq_done || first_zero ||
                    ((st_reg == HWS_ST_CAL) && cal_done) ||
                    (st_reg == HWS_ST_DIAG);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= HWS_ST_IDLE;
      slot_ptr_reg <= 3'h0;
      rep_reg <= 2'h0;
      main_reg <= 2'h0;
      seg_reg <= 2'h0;
      seg_left_reg <= 9'h001;
      wait_left_reg <= 7'h00;
      wid_reg <= 7'h00;
      cal_cnt_reg <= 32'h0;
    end else if (end_proc) begin
      st_reg <= HWS_ST_IDLE;
    end else if (start) begin
      cal_cnt_reg <= 32'h0;
      slot_ptr_reg <= 3'h0;
      main_reg <= i_sequence_repeat_count;
      case (hws_mode_e'(i_mode))
        HWS_MODE_SEQ: st_reg <= HWS_ST_FETCH;
        HWS_MODE_RTP: st_reg <= HWS_ST_RTP;
        HWS_MODE_CAL: st_reg <= HWS_ST_CAL;
        default: st_reg <= HWS_ST_DIAG;
      endcase
    end else begin
      case (st_reg)
        HWS_ST_FETCH: begin
          wid_reg <= cur_slot[6:0];
          rep_reg <= i_per_waveform_repeat;
          seg_reg <= 2'd0;
          seg_left_reg <= 9'h000;
          wait_left_reg <= cur_slot[6:0];
          st_reg <= slot_wait ? HWS_ST_WAIT : HWS_ST_PLAY;
        end
        HWS_ST_PLAY: begin
          if (seg_left_reg == 9'h000) seg_left_reg <= seg_len;
          else if (tick) begin
            if (seg_left_reg != 9'h001) seg_left_reg <= seg_left_reg - 9'h001;
            else if (seg_reg != 2'd3) begin
              seg_reg <= seg_reg + 2'd1;
              seg_left_reg <= 9'h000;
            end else if (rep_reg != 2'd0) begin
              rep_reg <= rep_reg - 2'd1;
              seg_reg <= 2'd0;
              seg_left_reg <= 9'h000;
            end
          end
          if (slot_done) begin
            st_reg <= HWS_ST_FETCH;
            slot_ptr_reg <= next_slot_zero ? 3'h0 : slot_ptr_reg + 3'h1;
            if (next_slot_zero) main_reg <= main_reg - 2'd1;
          end
        end
        HWS_ST_WAIT: begin
          if (wait_tick) wait_left_reg <= wait_left_reg - 7'h01;
          if (slot_done) begin
            st_reg <= HWS_ST_FETCH;
            slot_ptr_reg <= next_slot_zero ? 3'h0 : slot_ptr_reg + 3'h1;
            if (next_slot_zero) main_reg <= main_reg - 2'd1;
          end
        end
        HWS_ST_CAL: cal_cnt_reg <= cal_cnt_reg + 32'h1;
        default: st_reg <= st_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Go bit, calibration, diagnostics
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) go_reg <= 1'b0;
    else if (start) go_reg <= 1'b1;
    else if (end_proc) go_reg <= 1'b0;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) bgain_reg <= 2'h0;
    else if ((st_reg == HWS_ST_CAL) && cal_done) bgain_reg <= i_cal_best_gain;
    else if (i_backemf_amp_gain_we) bgain_reg <= i_backemf_amp_gain_wr;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fault_reg <= 1'b0;
      res_reg <= 8'h00;
    end else if (st_reg == HWS_ST_DIAG) begin
      fault_reg <= i_diag_open || i_diag_short;
      res_reg <= i_diag_meas;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) neg_dir_reg <= 1'b0;
    else if (start) neg_dir_reg <= i_lra_sel && i_motion_present && i_motion_dir;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drive level
  wire playing = (st_reg == HWS_ST_PLAY) && (seg_left_reg != 9'h000);
  wire [7:0] amp_code = (st_reg == HWS_ST_RTP) ? i_realtime_amplitude_playback :
                        playing ? hws_lib_amp(i_library_select, seg_reg) : 8'h00;
  wire [7:0] amp_mag = amp_code[7] ? 8'(-amp_code) : amp_code;
  wire [15:0] ol_prod = {8'h00, i_peak_clamp_level} * {8'h00, amp_mag};
  wire braking = playing && (seg_reg == 2'd3);
  wire ol_active = i_openloop && !(braking && i_openloop_autobrake_en);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) level_reg <= 8'h00;
    else level_reg <= ol_active ? ol_prod[14:7] : amp_mag;
  end
  assign o_drive_level = level_reg;
  assign o_drive_neg = amp_code[7] ^ neg_dir_reg;
  assign o_closed_loop = !ol_active;
  assign o_square_shape = ol_active && i_lra_sel && i_drive_shape_sel;
  assign o_drive_period = i_openloop_period;
  assign o_loop_gain = ol_active ? 2'h0 : i_loop_gain;
  assign o_backemf_amp_gain = bgain_reg;
  assign o_eff_backemf_amp_gain = {bgain_reg, 2'b00} + {2'b00, i_sample_time};
  assign o_diag_fault_flag = fault_reg;
  assign o_resistance_meas = res_reg;
  assign o_go = go_reg;
  assign o_busy = (st_reg != HWS_ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_GO_START: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_busy) |-> $past(i_go_set || pin_rise))
    else $error("busy without trigger");
  AST_GO_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(o_busy) |-> !o_go)
    else $error("go still set after end");
  AST_STOP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    stop_req |=> !o_busy)
    else $error("stop ignored");
  AST_FAULT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_reg == HWS_ST_DIAG) && (i_diag_open || i_diag_short) |=> o_diag_fault_flag)
    else $error("fault not flagged");
  AST_CALGAIN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_reg == HWS_ST_CAL) && cal_done |=> o_backemf_amp_gain == $past(i_cal_best_gain))
    else $error("cal gain not stored");
  AST_SHAPE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_lra_sel |-> !o_square_shape)
    else $error("shape used for rotating mass");
  AST_SLOT0: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    start && (hws_mode_e'(i_mode) == HWS_MODE_SEQ) |=> slot_ptr_reg == 3'h0)
    else $error("sequence not from first slot");
  sequence hws_wait_fetch_s;
    (st_reg == HWS_ST_FETCH) && slot_wait && !end_proc;
  endsequence
  AST_WAITSLOT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    hws_wait_fetch_s |=> st_reg == HWS_ST_WAIT)
    else $error("wait slot played");
endmodule : hws_sequencer

// file: verification/hws_host_model.sv
// Purpose: Host side model for trigger and slot accesses
// Assumes: Driven just after rising clock edges
// Notes: Released slot lines show the inverse of the last value
`timescale 1ns/1ps
module hws_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_slot_rdata,
  output logic o_go_set,
  output logic o_go_clr,
  output logic o_trigger_irq_pin,
  output logic o_slot_we,
  output logic [2:0] o_slot_idx,
  output logic [7:0] o_slot_wdata
);
  initial begin
    {o_go_set, o_go_clr, o_trigger_irq_pin, o_slot_we, o_slot_idx, o_slot_wdata} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle go or stop pulse
  task automatic pulse_go(input logic stop);
    @(posedge i_clk);
    if (stop) begin
      o_go_clr <= 1'b1;
    end else begin
      o_go_set <= 1'b1;
    end
    @(posedge i_clk);
    o_go_clr <= 1'b0;
    o_go_set <= 1'b0;
  endtask : pulse_go
  task automatic set_pin(input logic lvl);
    @(posedge i_clk);
    o_trigger_irq_pin <= lvl;
  endtask : set_pin
  task automatic write_slot(input logic [2:0] idx, input logic [7:0] data);
    @(posedge i_clk);
    o_slot_we <= 1'b1;
    o_slot_idx <= idx;
    o_slot_wdata <= data;
    @(posedge i_clk);
    o_slot_we <= 1'b0;
    o_slot_idx <= ~idx;
    o_slot_wdata <= ~data;
  endtask : write_slot
  task automatic read_slot(input logic [2:0] idx, output logic [7:0] data);
    @(posedge i_clk);
    o_slot_idx <= idx;
    @(negedge i_clk);
    data = i_slot_rdata;
  endtask : read_slot
endmodule : hws_host_model

// file: verification/hws_sequencer_bench.sv
// Purpose: Self-checking bench for the haptic waveform sequencer
// Assumes: Shortened tick and wait parameters
// Notes: Durations are checked within a small tolerance
`timescale 1ns/1ps
module hws_sequencer_bench;
  localparam int LONG = 20;
  localparam int SHORT = 4;
  localparam int WCYC = 40;
  localparam int CALU = 10;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic go_set, go_clr, pin, swe, pin_fn, lib, ivl, ol, lra, shp, ab, mp, md;
  logic dop, dsh, bwe, go, busy, neg, cl, sq, flag, seen_cl;
  logic [1:0] mode, wrep, srep, ctime, lg, st, bwr, best, olg, bg;
  logic [2:0] sidx;
  logic [3:0] eg;
  logic [6:0] per, dper;
  logic [7:0] swd, rd, rdv, overdrive_time_ofs, sustain_pos_time_ofs, sustain_neg_time_ofs, brake_time_ofs, amp, clamp, dm, lvl, res;
  int errors = 0;
  int cmp_count = 0;
  int n;
  always #2.5 i_clk = ~i_clk;
  always @(negedge i_clk) if (busy && cl) seen_cl = 1'b1;
  hws_sequencer #(.CAL_UNIT_CYC(CALU), .LONG_CYC(LONG), .SHORT_CYC(SHORT), .WAIT_CYC(WCYC))
  hws_sequencer_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go_set(go_set), .i_go_clr(go_clr),
    .i_trigger_irq_pin(pin), .i_trigger_pin_function(pin_fn), .i_mode(mode),
    .i_library_select(lib), .i_playback_interval(ivl), .i_slot_we(swe), .i_slot_idx(sidx),
    .i_slot_wdata(swd), .i_per_waveform_repeat(wrep), .i_sequence_repeat_count(srep),
    .i_overdrive_time_ofs(overdrive_time_ofs), .i_sustain_pos_time_ofs(sustain_pos_time_ofs), .i_sustain_neg_time_ofs(sustain_neg_time_ofs),
    .i_brake_time_ofs(brake_time_ofs), .i_realtime_amplitude_playback(amp), .i_openloop(ol),
    .i_lra_sel(lra), .i_peak_clamp_level(clamp), .i_openloop_period(per),
    .i_drive_shape_sel(shp), .i_openloop_autobrake_en(ab), .i_cal_time(ctime),
    .i_loop_gain(lg), .i_sample_time(st), .i_backemf_amp_gain_wr(bwr),
    .i_backemf_amp_gain_we(bwe), .i_cal_best_gain(best), .i_motion_present(mp),
    .i_motion_dir(md), .i_diag_open(dop), .i_diag_short(dsh), .i_diag_meas(dm),
    .o_go(go), .o_slot_rdata(rd), .o_busy(busy), .o_drive_level(lvl), .o_drive_neg(neg),
    .o_closed_loop(cl), .o_square_shape(sq), .o_drive_period(dper), .o_loop_gain(olg),
    .o_backemf_amp_gain(bg), .o_eff_backemf_amp_gain(eg), .o_diag_fault_flag(flag),
    .o_resistance_meas(res)
  );
  hws_host_model hws_host_model_i (
    .i_clk(i_clk), .i_slot_rdata(rd), .o_go_set(go_set), .o_go_clr(go_clr),
    .o_trigger_irq_pin(pin), .o_slot_we(swe), .o_slot_idx(sidx), .o_slot_wdata(swd)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input int v, input int e, input int t);
    chk(16'((v >= e - t) && (v <= e + t)), 16'h1);
  endtask : near
  task automatic start(input logic [1:0] m);
    @(posedge i_clk);
    mode <= m;
    hws_host_model_i.pulse_go(1'b0);
    @(negedge i_clk);
    chk(16'(go), 16'h1);
  endtask : start
  // Count busy cycles, bounded
  task automatic await_idle(output int cyc);
    cyc = 0;
    while (busy === 1'b1) begin
      cyc++;
      if (cyc > 20000) begin
        errors++;
        complete_run();
      end
      @(negedge i_clk);
    end
    chk(16'(go), 16'h0);
  endtask : await_idle
  task automatic run(input logic [1:0] m);
    start(m);
    await_idle(n);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {pin_fn, lib, ivl, ol, lra, shp, ab, mp, md, dop, dsh, bwe, seen_cl} = '0;
    {mode, wrep, srep, ctime, lg, st, bwr, best} = '0;
    {overdrive_time_ofs, sustain_pos_time_ofs, sustain_neg_time_ofs, brake_time_ofs, amp, clamp, dm} = '0;
    per = 7'h00;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    chk({14'h0, busy, go}, 16'h0);
    for (int i = 0; i < 8; i++) begin
      hws_host_model_i.read_slot(3'(i), rdv);
      chk(16'(rdv), 16'h0);
      hws_host_model_i.write_slot(3'(i), 8'hA0 + 8'(i));
      hws_host_model_i.read_slot(3'(i), rdv);
      chk(16'(rdv), 16'hA0 + 16'(i));
    end
    @(posedge i_clk);
    {bwr, bwe} <= 3'b011;
    @(posedge i_clk);
    bwe <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      @(posedge i_clk);
      st <= 2'(s);
      @(negedge i_clk);
      chk(16'(eg), 16'h4 + 16'(s));
    end
    hws_host_model_i.write_slot(3'h0, 8'h01);
    hws_host_model_i.write_slot(3'h1, 8'h00);
    @(posedge i_clk);
    lib <= 1'b1;
    run(2'h1);
    near(n, 18 * LONG, LONG + 4);
    @(posedge i_clk);
    ivl <= 1'b1;
    run(2'h1);
    near(n, 18 * SHORT, SHORT + 4);
    @(posedge i_clk);
    lib <= 1'b0;
    run(2'h1);
    near(n, 26 * SHORT, SHORT + 4);
    @(posedge i_clk);
    {lib, overdrive_time_ofs, sustain_pos_time_ofs, sustain_neg_time_ofs, brake_time_ofs} <= {1'b1, 32'h0501FFFE};
    run(2'h1);
    near(n, 21 * SHORT, SHORT + 4);
    @(posedge i_clk);
    {overdrive_time_ofs, sustain_pos_time_ofs, sustain_neg_time_ofs, brake_time_ofs, srep} <= {32'h0, 2'h1};
    run(2'h1);
    near(n, 36 * SHORT, 2 * SHORT + 6);
    @(posedge i_clk);
    {srep, wrep} <= 4'h2;
    run(2'h1);
    chk(16'(n > 27 * SHORT), 16'h1);
    @(posedge i_clk);
    {wrep, ol, lra, ab, seen_cl} <= 6'h0A;
    run(2'h1);
    chk(16'(seen_cl), 16'h1);
    @(posedge i_clk);
    {ab, seen_cl} <= 2'b00;
    run(2'h1);
    chk(16'(seen_cl), 16'h0);
    hws_host_model_i.write_slot(3'h0, 8'h83);
    run(2'h1);
    near(n, 3 * WCYC, 10);
    for (int i = 0; i < 8; i++) hws_host_model_i.write_slot(3'(i), 8'h01);
    run(2'h1);
    near(n, 144 * SHORT, 24);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      {dop, dsh, dm} <= {2'(1 << k), 8'h5A + 8'(k)};
      run(2'h2);
      chk(16'(flag), 16'(k < 2));
      chk(16'(res), 16'h5A + 16'(k));
    end
    @(posedge i_clk);
    best <= 2'h2;
    for (int c = 0; c < 2; c++) begin
      @(posedge i_clk);
      ctime <= 2'(c);
      run(2'h3);
      near(n, (c + 1) * CALU, 2);
    end
    chk(16'(bg), 16'h2);
    @(posedge i_clk);
    {ctime, pin_fn, mode} <= 5'h1F;
    hws_host_model_i.set_pin(1'b1);
    repeat (30) @(negedge i_clk);
    chk(16'(busy), 16'h1);
    hws_host_model_i.set_pin(1'b0);
    await_idle(n);
    near(n, 2, 2);
    @(posedge i_clk);
    {pin_fn, ol, lra, shp, clamp, amp, per, overdrive_time_ofs, lg} <= {4'h7, 16'h4040, 7'h2A, 8'h05, 2'h3};
    start(2'h0);
    repeat (50) @(negedge i_clk);
    chk(16'(lvl), 16'h20);
    chk({12'h0, cl, sq, olg}, 16'h4);
    chk({dper, busy}, 16'h55);
    @(posedge i_clk);
    lra <= 1'b0;
    @(negedge i_clk);
    chk(16'(sq), 16'h0);
    hws_host_model_i.pulse_go(1'b1);
    await_idle(n);
    near(n, 1, 2);
    for (int m = 0; m < 2; m++) begin
      @(posedge i_clk);
      {ol, lra, mp, md, overdrive_time_ofs} <= {2'b01, 1'(m), 9'h100};
      start(2'h0);
      repeat (3) @(negedge i_clk);
      chk({cl, neg, sq, olg}, {1'b1, 1'(m), 3'h3});
      hws_host_model_i.pulse_go(1'b1);
      await_idle(n);
    end
    complete_run();
  end
endmodule : hws_sequencer_bench
